/* File: regload_slice.sv */
/*
 * Decode and execute logic for three one-word, one-cycle register loads:
 * the pair register from auxiliary and accumulator, and the two port
 * output structure control registers from the accumulator.
 * Assumes the fetch path presents one instruction per cycle with a valid
 * strobe, and that accumulator and auxiliary values are stable with it.
 */
// Summary of operation
// - Opcode 01a loads pair register, one cycle.
// - Auxiliary to pair high, accumulator to low.
// - Opcode 228 loads output structure zero.
// - Accumulator replaces output structure zero whole.
// - Opcode 229 loads output structure one.
// - Accumulator replaces output structure one whole.
`timescale 1ns/1ps
`default_nettype none
module regload_slice (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Instruction from fetch.
  input wire logic i_instr_valid,
  input wire logic [9:0] i_instr_opcode,
  // Register file values.
  input wire logic [3:0] i_acc,
  input wire logic [3:0] i_aux,
  // Results.
  output logic [7:0] o_pair,
  output logic [3:0] o_port_outstruct_ctrl_zero,
  output logic [3:0] o_port_outstruct_ctrl_one,
  output logic o_done,
  output logic o_carry_write,
  output logic o_acc_write,
  output logic o_aux_write,
  output logic o_skip_next
);
  ////////////////////////////////////////////////////////////////////////
  // Decoded operation and the load selects drawn from it.
  regload_pkg::dec_t dec;
  wire logic do_pair;
  wire logic do_zero;
  wire logic do_one;
  wire logic do_any;
  wire logic [7:0] next_pair;
  wire logic [3:0] next_zero;
  wire logic [3:0] next_one;
  wire logic next_done;

  regload_decode regload_decode_i (
    .i_valid(i_instr_valid),
    .i_opcode(i_instr_opcode),
    .o_dec(dec)
  );

  assign do_pair = (dec == regload_pkg::DEC_PAIR);
  assign do_zero = (dec == regload_pkg::DEC_OS_ZERO);
  assign do_one = (dec == regload_pkg::DEC_OS_ONE);
  assign do_any = do_pair || do_zero || do_one;

  ////////////////////////////////////////////////////////////////////////
  // Next values. A target that this cycle's load does not address keeps
  // its contents, so a refused word changes nothing.
  assign next_pair = do_pair ? {i_aux, i_acc} : o_pair;
  assign next_zero = do_zero ? i_acc
    : o_port_outstruct_ctrl_zero;
  assign next_one = do_one ? i_acc
    : o_port_outstruct_ctrl_one;
  assign next_done = do_any;

  ////////////////////////////////////////////////////////////////////////
  // Pair register: auxiliary in the high nibble, accumulator in the low.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_pair <= regload_pkg::PAIR_RESET;
    end else begin
      o_pair <= next_pair;
    end
  end

  // Output structure control register zero.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_port_outstruct_ctrl_zero <= regload_pkg::OUTSTRUCT_RESET;
    end else begin
      o_port_outstruct_ctrl_zero <= next_zero;
    end
  end

  // Output structure control register one.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_port_outstruct_ctrl_one <= regload_pkg::OUTSTRUCT_RESET;
    end else begin
      o_port_outstruct_ctrl_one <= next_one;
    end
  end

  // Completion pulse, high for the one cycle after a recognised load.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_done <= 1'h0;
    end else begin
      o_done <= next_done;
    end
  end

  // These loads never write carry, accumulator, auxiliary or skip. The
  // strobes stay flops with no reset, so the core sees a registered zero from the first clock edge on.
  always_ff @(posedge i_sys_clk) begin
    o_carry_write <= 1'h0;
    o_acc_write <= 1'h0;
    o_aux_write <= 1'h0;
    o_skip_next <= 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the ports. They decode the opcode on their own, so a slip
  // in the decoder submodule is caught here as well.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  function automatic logic op_hit(
    input logic valid,
    input logic [9:0] opcode,
    input logic [9:0] code
  );
    op_hit = valid && (opcode == code);
  endfunction

  function automatic logic any_hit(
    input logic valid,
    input logic [9:0] opcode
  );
    any_hit = op_hit(valid, opcode, regload_pkg::OP_PAIR_LOAD)
      || op_hit(valid, opcode, regload_pkg::OP_OUTSTRUCT_ZERO)
      || op_hit(valid, opcode, regload_pkg::OP_OUTSTRUCT_ONE);
  endfunction

  sequence s_pair_issue;
    op_hit(i_instr_valid, i_instr_opcode, regload_pkg::OP_PAIR_LOAD);
  endsequence

  sequence s_zero_issue;
    op_hit(i_instr_valid, i_instr_opcode, regload_pkg::OP_OUTSTRUCT_ZERO);
  endsequence

  sequence s_one_issue;
    op_hit(i_instr_valid, i_instr_opcode, regload_pkg::OP_OUTSTRUCT_ONE);
  endsequence

  sequence s_any_issue;
    any_hit(i_instr_valid, i_instr_opcode);
  endsequence

  sequence s_idle;
    !any_hit(i_instr_valid, i_instr_opcode);
  endsequence

  // A load followed by a cycle that loads nothing.
  sequence s_load_then_idle;
    s_any_issue ##1 s_idle;
  endsequence

  a_pair_load_done: assert property (
    s_pair_issue |=> o_done)
    else $error("pair load did not finish in one cycle");

  a_pair_high_aux: assert property (
    s_pair_issue |=> o_pair[7:4] == $past(i_aux))
    else $error("pair high nibble not from auxiliary");

  a_pair_low_acc: assert property (
    s_pair_issue |=> o_pair[3:0] == $past(i_acc))
    else $error("pair low nibble not from accumulator");

  a_pair_hold: assert property (
    !op_hit(i_instr_valid, i_instr_opcode, regload_pkg::OP_PAIR_LOAD)
    |=> $stable(o_pair))
    else $error("pair register changed without load");

  a_zero_decode: assert property (
    s_zero_issue |=> o_done)
    else $error("output structure zero load not decoded");

  a_zero_load: assert property (
    s_zero_issue |=> o_port_outstruct_ctrl_zero == $past(i_acc))
    else $error("output structure zero not loaded");

  a_zero_hold: assert property (
    !op_hit(i_instr_valid, i_instr_opcode, regload_pkg::OP_OUTSTRUCT_ZERO)
    |=> $stable(o_port_outstruct_ctrl_zero))
    else $error("output structure zero changed without load");

  a_one_decode: assert property (
    s_one_issue |=> o_done)
    else $error("output structure one load not decoded");

  a_one_load: assert property (
    s_one_issue |=> o_port_outstruct_ctrl_one == $past(i_acc))
    else $error("output structure one not loaded");

  a_one_hold: assert property (
    !op_hit(i_instr_valid, i_instr_opcode, regload_pkg::OP_OUTSTRUCT_ONE)
    |=> $stable(o_port_outstruct_ctrl_one))
    else $error("output structure one changed without load");

  a_done_idle: assert property (
    s_idle |=> !o_done)
    else $error("completion raised without a recognised load");

  a_done_pulse: assert property (
    s_load_then_idle |-> o_done ##1 !o_done)
    else $error("completion pulse not one cycle long");

  a_no_side_effect: assert property (
    o_done |-> !o_carry_write && !o_acc_write && !o_aux_write
      && !o_skip_next)
    else $error("load caused a side effect");

  a_no_skip_follow: assert property (
    s_any_issue |=> !o_skip_next ##1 !o_skip_next)
    else $error("load caused the next instruction to be skipped");
endmodule
`default_nettype wire

/* File: regload_pkg.sv */
/*
 * Package for the register-load instruction slice: opcodes, widths and
 * reset values shared by the decoder and the execute logic.
 * Assumes a 10-bit program word and 4-bit data registers.
 */
`default_nettype none
package regload_pkg;
  localparam int unsigned OP_W = 10;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned PAIR_W = 8;
  localparam logic [9:0] OP_PAIR_LOAD = 10'h01a;
  localparam logic [9:0] OP_OUTSTRUCT_ZERO = 10'h228;
  localparam logic [9:0] OP_OUTSTRUCT_ONE = 10'h229;
  localparam logic [7:0] PAIR_RESET = 8'h00;
  localparam logic [3:0] OUTSTRUCT_RESET = 4'h0;
  localparam int unsigned PAIR_HI_LSB = 4;
  localparam int unsigned PAIR_LO_LSB = 0;
  typedef enum {DEC_NONE, DEC_PAIR, DEC_OS_ZERO, DEC_OS_ONE} dec_t;
endpackage
`default_nettype wire

/* File: regload_decode.sv */
/*
 * Opcode decoder for the register-load instruction slice.
 * Assumes the opcode is valid only while i_valid is high.
 */
`timescale 1ns/1ps
`default_nettype none
module regload_decode (
  // Fetched instruction.
  input wire logic i_valid,
  input wire logic [9:0] i_opcode,
  // Decoded operation.
  output var regload_pkg::dec_t o_dec
);
  wire logic hit_pair;
  wire logic hit_zero;
  wire logic hit_one;

  assign hit_pair = i_valid
    && (i_opcode == regload_pkg::OP_PAIR_LOAD);
  assign hit_zero = i_valid
    && (i_opcode == regload_pkg::OP_OUTSTRUCT_ZERO);
  assign hit_one = i_valid
    && (i_opcode == regload_pkg::OP_OUTSTRUCT_ONE);

  assign o_dec = hit_pair ? regload_pkg::DEC_PAIR :
                 hit_zero ? regload_pkg::DEC_OS_ZERO :
                 hit_one ? regload_pkg::DEC_OS_ONE :
                 regload_pkg::DEC_NONE;
endmodule
`default_nettype wire

/* File: regload_fetch_model.sv */
/* Fetch path and register file model for the slice.
   Assumes the bench drives its requests at the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module regload_fetch_model (
  // Clock.
  input wire logic i_sys_clk,
  // Request.
  input wire logic i_req,
  input wire logic [9:0] i_op,
  input wire logic [3:0] i_a,
  input wire logic [3:0] i_b,
  // To the slice.
  output logic o_valid,
  output logic [9:0] o_op,
  output logic [3:0] o_acc,
  output logic [3:0] o_aux
);
  logic [9:0] junk = 10'h155;
  // Between fetches the word toggles, so a stale opcode is never seen.
  always @(posedge i_sys_clk) junk <= ~junk;
  assign o_valid = i_req;
  assign o_op = i_req ? i_op : junk;
  assign o_acc = i_a;
  assign o_aux = i_b;
endmodule
`default_nettype wire

/* File: register_load_instruction_slice_bench.sv */
/* Self-checking bench for the register-load slice.
   Assumes the fetch model file is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module register_load_instruction_slice_bench;
  logic clk = 1'b0, rstn = 1'b0, req = 1'b0, valid, done, cw, aw, xw, sk;
  logic [9:0] op = 10'h000, opc;
  logic [3:0] a = 4'h0, b = 4'h0, acc, aux, fz, fo;
  logic [7:0] pair;
  int failures = 0, total_checks = 0;
  always #50 clk = ~clk;
  regload_fetch_model regload_fetch_model_i (.i_sys_clk(clk), .i_req(req),
    .i_op(op), .i_a(a), .i_b(b), .o_valid(valid), .o_op(opc),
    .o_acc(acc), .o_aux(aux));
  regload_slice regload_slice_i (.i_sys_clk(clk), .i_rstn(rstn),
    .i_instr_valid(valid), .i_instr_opcode(opc), .i_acc(acc), .i_aux(aux),
    .o_pair(pair), .o_port_outstruct_ctrl_zero(fz),
    .o_port_outstruct_ctrl_one(fo), .o_done(done), .o_carry_write(cw),
    .o_acc_write(aw), .o_aux_write(xw), .o_skip_next(sk));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task go(input logic v, input logic [9:0] o, input logic [3:0] x, y);
    @(posedge clk);
    req <= v;
    op <= o;
    a <= x;
    b <= y;
    @(posedge clk);
    req <= 1'b0;
    #1;
  endtask
  task t_pair;
    go(1'b1, 10'h01a, 4'h3, 4'ha);
    chk(pair, 8'ha3);
    chk({7'h00, done}, 8'h01);
    chk({4'h0, cw, aw, xw, sk}, 8'h00);
    $display("pair load test done");
  endtask
  task t_outstruct;
    go(1'b1, 10'h228, 4'h5, 4'hf);
    chk({fz, fo}, 8'h50);
    chk({7'h00, done}, 8'h01);
    go(1'b1, 10'h229, 4'hc, 4'h0);
    chk({fz, fo}, 8'h5c);
    chk({7'h00, done}, 8'h01);
    @(posedge clk);
    req <= 1'b1;
    op <= 10'h228;
    a <= 4'h9;
    @(posedge clk);
    op <= 10'h229;
    a <= 4'h6;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk({fz, fo}, 8'h96);
    chk({4'h0, cw, aw, xw, sk}, 8'h00);
    $display("output structure test done");
  endtask
  task t_refuse;
    go(1'b0, 10'h228, 4'h7, 4'h7);
    chk({fz, fo}, 8'h96);
    go(1'b1, 10'h22a, 4'h7, 4'h7);
    chk({fz, fo}, 8'h96);
    chk({pair[3:0], 3'h0, done}, 8'h30);
    $display("refusal test done");
  endtask
  task t_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(pair, 8'h00);
    chk({fz, fo}, 8'h00);
    chk({3'h0, done, cw, aw, xw, sk}, 8'h00);
    go(1'b1, 10'h01a, 4'h4, 4'h2);
    chk(pair, 8'h24);
    $display("reset test done");
  endtask
  task finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_pair;
    t_outstruct;
    t_refuse;
    t_reset;
    finish_test;
  end
  initial begin
    #20000;
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire
